// File: design/srs_ctrl.sv
// Purpose: reset, soft reset and standby sequencer of the camera chip
// Assumes: clk is input_ref_clock; rst_n is the hard reset pin
// Notes: registers reached from the two-wire serial front end
// How it works
// - hard reset pin low puts the device in reset
// - in reset outputs are high impedance, MIPI lines driven low
// - internal boot ends within 6000 clocks after reset release
// - reset_control bit 0 resets the device like the pin
// - soft reset completes within 6000 clocks; here it counts 6000, then waits for bit 0 to clear
// - standby entry takes at least one frame plus 40 clocks
// - three standby modes, override bit, retained settings kept
// - soft standby stops core, serial interface and registers stay
// - low leakage standby cuts core power, wipes, restarts on release
// - retention select before pin gives high leakage mode
// - high leakage standby stops clocks, resumes prior state
// - standby pin high enters hard standby, low leaves it
// - hard standby gates clock, serial interface and pipeline
// - enable bit 3 first, request raises microcontroller interrupt
// - bit 0 requests soft standby, bit 14 reports it reached
// - clearing bit 0 leaves soft standby, bit 14 then clears
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"
module srs_ctrl
   import srs_pkg::*;
#(
   parameter logic [15:0] BOOT_CYCLES  = `SRS_BOOT_MAX,
   parameter logic [15:0] SRST_CYCLES  = `SRS_SRST_MAX,
   parameter logic [15:0] FRAME_CYCLES = `SRS_FRAME_DEF
) (
   // clock and hard reset pin
   input  wire logic     clk,
   input  wire logic     rst_n,
   // hard standby pin, active high
   input  wire logic     standby,
   // register port from the serial front end
   input  wire srs_req_t req,
   output var  logic [15:0] rdata,
   // control outputs
   output var  srs_ctl_t ctl
);

   // parked in reset
   // core and pipeline off, outputs parked, clocks and serial interface on, as seen during hard reset
   localparam srs_ctl_t CTL_RST = '{
      core_en : 1'b0, pipe_en : 1'b0, sif_en : 1'b1,
      iclk_en : 1'b1, vdd_en : 1'b1, par_oe_n : 1'b1,
      mipi_low : 1'b1, mcu_irq : 1'b0, mcu_rst : 1'b1,
      wipe : 1'b0};
   localparam srs_st_t ST_RST = '{
      state : SRS_BOOT, resume : SRS_ACTIVE, cnt : '0,
      stby : `SRS_ZERO16, rstc : `SRS_ZERO16,
      rdata : `SRS_ZERO16, ctl : CTL_RST};

   srs_st_t     st;
   srs_st_t     nx;
   logic [16:0] ent_tgt;
   logic [16:0] cnt_inc;
   logic        wr_stby;
   logic        wr_rst;
   logic        hard_go;
   logic        soft_go;

   // decoded writes; ignored while the serial interface is shut
   assign wr_stby = req.wr && st.ctl.sif_en && (req.addr == `SRS_OFS_STBY);
   assign wr_rst  = req.wr && st.ctl.sif_en && (req.addr == `SRS_OFS_RST);
   assign ent_tgt = {1'b0, FRAME_CYCLES} + `SRS_ENTRY_ADD;
   assign cnt_inc = st.cnt + `SRS_ONE17;
   // override bit blocks entry into any standby mode
   assign hard_go = standby && !st.stby[`SRS_B_OVR];
   assign soft_go = st.stby[`SRS_B_REQ] && st.stby[`SRS_B_EN] &&
                    !st.stby[`SRS_B_OVR];

   // next state of the whole controller
   always_comb begin
      nx = st;
      nx.ctl.mcu_irq = 1'b0;
      nx.ctl.wipe    = 1'b0;
      // registered read data; unmapped offsets read zero
      if (req.rd) begin
         if (req.addr == `SRS_OFS_STBY) begin
            nx.rdata = st.stby;
         end else if (req.addr == `SRS_OFS_RST) begin
            nx.rdata = st.rstc;
         end else begin
            nx.rdata = `SRS_ZERO16;
         end
      end
      // status bit is read only, writes keep it
      if (wr_stby) begin
         nx.stby = (req.wdata & `SRS_STBY_WMASK) | (st.stby & `SRS_DONE_MASK);
      end
      // request with enable interrupts the microcontroller
      if (wr_stby && req.wdata[`SRS_B_REQ] && req.wdata[`SRS_B_EN] &&
          !st.stby[`SRS_B_REQ]) begin
         nx.ctl.mcu_irq = 1'b1;
      end
      if (wr_rst) begin
         nx.rstc = req.wdata & `SRS_RST_WMASK;
      end
      case (st.state)
         SRS_BOOT: begin
            if (st.cnt == {1'b0, BOOT_CYCLES - `SRS_ONE16}) begin
               nx.state = SRS_ACTIVE;
               nx.cnt   = '0;
            end else begin
               nx.cnt = cnt_inc;
            end
         end
         SRS_ACTIVE: begin
            nx.cnt = '0;
            if (st.rstc[`SRS_B_CORE]) begin
               nx.state = SRS_SRST;
               nx.stby  = `SRS_ZERO16;
            end else if (hard_go) begin
               nx.state  = SRS_HENTER;
               nx.resume = SRS_ACTIVE;
            end else if (soft_go) begin
               // soft standby entry starts only from the active state
               nx.state = SRS_SENTER;
            end
         end
         // soft reset runs its full count, then ends once bit 0 is cleared
         SRS_SRST: begin
            if (st.cnt != {1'b0, SRST_CYCLES - `SRS_ONE16}) begin
               nx.cnt = cnt_inc;
            end else if (!st.rstc[`SRS_B_CORE]) begin
               nx.state = SRS_ACTIVE;
               nx.cnt   = '0;
            end
         end
         SRS_SENTER: begin
            if (hard_go) begin
               nx.state  = SRS_HENTER;
               nx.resume = SRS_ACTIVE;
               nx.cnt    = '0;
            end else if (!st.stby[`SRS_B_REQ]) begin
               nx.state = SRS_ACTIVE;
               nx.cnt   = '0;
            end else if (st.cnt == ent_tgt - `SRS_ONE17) begin
               nx.state = SRS_SSTBY;
               nx.stby[`SRS_B_DONE] = 1'b1;
               nx.cnt   = '0;
            end else begin
               nx.cnt = cnt_inc;
            end
         end
         SRS_SSTBY: begin
            if (hard_go) begin
               nx.state  = SRS_HENTER;
               nx.resume = SRS_SSTBY;
            end else if (!st.stby[`SRS_B_REQ]) begin
               nx.state = SRS_ACTIVE;
               nx.stby[`SRS_B_DONE] = 1'b0;
            end
         end
         SRS_HENTER: begin
            if (!standby) begin
               nx.state = st.resume;
               nx.cnt   = '0;
            end else if (st.cnt == ent_tgt - `SRS_ONE17) begin
               nx.state = SRS_HSTBY;
               nx.cnt   = '0;
            end else begin
               nx.cnt = cnt_inc;
            end
         end
         SRS_HSTBY: begin
            if (!standby) begin
               // retention chosen before the pin decides mode
               if (st.stby[`SRS_B_RET]) begin
                  nx.state = st.resume;
               end else begin
                  // variables lost, restart as after power up
                  nx.state   = SRS_BOOT;
                  nx.stby    = `SRS_ZERO16;
                  nx.rstc    = `SRS_ZERO16;
                  nx.ctl.wipe = 1'b1;
               end
            end
         end
         default: begin
            nx.state = SRS_BOOT;
            nx.cnt   = '0;
         end
      endcase
      // output decode from the next state so outputs are registered
      nx.ctl.core_en  = 1'b0;
      nx.ctl.pipe_en  = 1'b0;
      nx.ctl.sif_en   = 1'b1;
      nx.ctl.iclk_en  = 1'b1;
      nx.ctl.vdd_en   = 1'b1;
      nx.ctl.par_oe_n = 1'b1;
      nx.ctl.mipi_low = 1'b1;
      case (nx.state)
         // entry phases keep running for one frame plus 40 clocks
         SRS_ACTIVE, SRS_SENTER, SRS_HENTER: begin
            nx.ctl.core_en  = 1'b1;
            nx.ctl.pipe_en  = 1'b1;
            nx.ctl.par_oe_n = 1'b0;
            nx.ctl.mipi_low = 1'b0;
         end
         // clock, serial interface and pipeline gated
         SRS_HSTBY: begin
            nx.ctl.sif_en  = 1'b0;
            nx.ctl.iclk_en = 1'b0;
            nx.ctl.vdd_en  = nx.stby[`SRS_B_RET];
         end
         default: begin
            nx.ctl.core_en = 1'b0;
         end
      endcase
      // wipe leaves patch, PLL and IO selections alone
      nx.ctl.mcu_rst = nx.rstc[`SRS_B_MCU] || (nx.state == SRS_SRST) ||
                       (nx.state == SRS_BOOT);
   end

   // pin low forces the reset state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= ST_RST;
      end else begin
         st <= nx;
      end
   end

   assign rdata = st.rdata;
   assign ctl   = st.ctl;

   // cycles spent in the present state, read by checks only
   logic [16:0] age;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         age <= '0;
      end else if (nx.state == st.state) begin
         age <= age + `SRS_ONE17;
      end else begin
         age <= '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_park: assert property (
      $past(!rst_n) |-> ctl.par_oe_n && ctl.mipi_low && !ctl.core_en)
      else $error("outputs not parked after hard reset");
   a_boot_bound: assert property (
      st.state == SRS_BOOT |-> age < {1'b0, BOOT_CYCLES})
      else $error("boot longer than allowed");
   a_srst_hold: assert property (
      st.state == SRS_SRST |-> !ctl.core_en && ctl.mcu_rst && ctl.par_oe_n)
      else $error("core running during soft reset");
   a_srst_done: assert property (
      st.state == SRS_SRST && age >= {1'b0, SRST_CYCLES - `SRS_ONE16}
      |-> st.cnt == {1'b0, SRST_CYCLES - `SRS_ONE16})
      else $error("soft reset not complete in time");
   a_entry_min: assert property (
      $rose(st.stby[`SRS_B_DONE]) |-> $past(age) >= ent_tgt - `SRS_ONE17)
      else $error("standby reported too early");
   a_soft_alive: assert property (
      st.state == SRS_SSTBY |-> ctl.sif_en && !ctl.core_en && ctl.iclk_en)
      else $error("soft standby outputs wrong");
   a_hard_gate: assert property (
      st.state == SRS_HSTBY |-> !ctl.sif_en && !ctl.iclk_en && !ctl.pipe_en)
      else $error("hard standby not gated");
   a_leak_exit: assert property (
      st.state == SRS_HSTBY && !standby && !st.stby[`SRS_B_RET]
      |=> st.state == SRS_BOOT && ctl.wipe && ctl.vdd_en)
      else $error("low leakage exit did not restart");
   a_leak_power: assert property (
      st.state == SRS_HSTBY |-> ctl.vdd_en == st.stby[`SRS_B_RET])
      else $error("core power does not follow retention");
   a_keep_resume: assert property (
      st.state == SRS_HSTBY && !standby && st.stby[`SRS_B_RET]
      |=> st.state == $past(st.resume) && !ctl.wipe)
      else $error("high leakage exit lost state");
   a_irq_pulse: assert property (
      wr_stby && req.wdata[`SRS_B_REQ] && req.wdata[`SRS_B_EN] &&
      !st.stby[`SRS_B_REQ] |=> ctl.mcu_irq ##1 !ctl.mcu_irq)
      else $error("missing standby interrupt");
   a_pin_entry: assert property (
      st.state == SRS_ACTIVE && hard_go && !st.rstc[`SRS_B_CORE]
      |=> st.state == SRS_HENTER)
      else $error("standby pin ignored");
   a_soft_leave: assert property (
      st.state == SRS_SSTBY && !st.stby[`SRS_B_REQ] && !hard_go
      |=> st.state == SRS_ACTIVE && !st.stby[`SRS_B_DONE])
      else $error("soft standby exit wrong");

   c_soft_stby: cover property (st.state == SRS_SENTER ##1 st.state == SRS_SSTBY);
   c_hard_stby: cover property (st.state == SRS_HENTER ##1 st.state == SRS_HSTBY);
   c_soft_rst:  cover property (st.state == SRS_SRST ##1 st.state == SRS_ACTIVE);
   c_resume:    cover property (st.state == SRS_HSTBY ##1 st.state == SRS_SSTBY);

endmodule : srs_ctrl
`default_nettype wire

// File: design/srs_consts.svh
// Purpose: named constants of the reset and standby controller
// Assumes: every count is in cycles of input_ref_clock
// Notes: definitions only
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
// register offsets on the system_control_map
`define SRS_OFS_STBY   16'h0018
`define SRS_OFS_RST    16'h001a
// standby_control_status fields
`define SRS_B_REQ      0
`define SRS_B_RET      2
`define SRS_B_EN       3
`define SRS_B_OVR      5
`define SRS_B_DONE     14
`define SRS_STBY_WMASK 16'h002d
`define SRS_DONE_MASK  16'h4000
// reset_control fields
`define SRS_B_CORE     0
`define SRS_B_MCU      1
`define SRS_RST_WMASK  16'h0003
// timing counts
`define SRS_BOOT_MAX   16'h1770
`define SRS_SRST_MAX   16'h1770
`define SRS_FRAME_DEF  16'h03e8
`define SRS_ENTRY_ADD  17'h00028
`define SRS_ONE17      17'h00001
`define SRS_ONE16      16'h0001
`define SRS_ZERO16     16'h0000
`endif

// File: design/srs_pkg.sv
// Purpose: types of the reset and standby controller
// Assumes: one clock domain
// Notes: constants live in srs_consts.svh
package srs_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      SRS_BOOT   = 3'b000,
      SRS_ACTIVE = 3'b001,
      SRS_SRST   = 3'b010,
      SRS_SENTER = 3'b011,
      SRS_SSTBY  = 3'b100,
      SRS_HENTER = 3'b101,
      SRS_HSTBY  = 3'b110
   } srs_state_t;
   // register access from the two-wire serial front end
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } srs_req_t;
   // control outputs to the rest of the chip
   typedef struct packed {
      logic core_en;
      logic pipe_en;
      logic sif_en;
      logic iclk_en;
      logic vdd_en;
      logic par_oe_n;
      logic mipi_low;
      logic mcu_irq;
      logic mcu_rst;
      logic wipe;
   } srs_ctl_t;
   // whole state of the controller
   typedef struct packed {
      srs_state_t  state;
      srs_state_t  resume;
      logic [16:0] cnt;
      logic [15:0] stby;
      logic [15:0] rstc;
      logic [15:0] rdata;
      srs_ctl_t    ctl;
   } srs_st_t;
endpackage : srs_pkg

// File: verification/srs_host_model.sv
// Purpose: host side of the reset and standby controller: pins and register port
// Assumes: requests change at the falling edge, one-cycle strobes
// Notes: tasks are called from the testbench by hierarchical name
`timescale 1ns/100ps
`default_nettype none
module srs_host_model
   import srs_pkg::*;
(
   // clock
   input  wire logic        clk,
   // pins toward the block
   output var  logic        rst_n,
   output var  logic        standby,
   // register port toward the block
   output var  srs_req_t    req,
   input  wire logic [15:0] rdata
);
   // pins start in reset with standby low, so nothing is requested early
   initial begin
      rst_n   = 1'b0;
      standby = 1'b0;
      req     = '0;
   end

   // full reset pulse
   // the clock never stops here, so both edges see it running
   task automatic hard_reset();
      @(negedge clk) rst_n = 1'b0;
      repeat (100) @(negedge clk);
      rst_n = 1'b1;
   endtask : hard_reset

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk) req = '0;
   endtask : wr

   // read data is sampled one cycle late; it holds until the next read anyway
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge clk) req = '0;
      @(negedge clk) d = rdata;
   endtask : rd

   task automatic pin(input logic v);
      @(negedge clk) standby = v;
   endtask : pin

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
endmodule : srs_host_model
`default_nettype wire

// File: verification/test_sensor_reset_standby_control.sv
// Purpose: self-checking bench of the reset and standby controller
// Assumes: short counts 16, 16 and 8 stand in for the long ones
// Notes: ctl is compared under a mask; irq and wipe pulses are counted
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"
module test_sensor_reset_standby_control
   import srs_pkg::*;
;
   localparam int BOOT_N  = 16;
   localparam int SRST_N  = 16;
   localparam int FRAME_N = 8;
   // masked ctl views: active, reset, low and high leakage hard standby
   localparam logic [9:0] M_ALL = 10'h3fa;
   localparam logic [9:0] M_HS  = 10'h3f8;

   logic        clk;
   logic        rst_n;
   logic        standby;
   srs_req_t    req;
   logic [15:0] rdata;
   srs_ctl_t    ctl;
   logic [15:0] d;
   int          err_count;
   int          num_checks;
   int          irq_n;
   int          wipe_n;
   int          k;

   srs_ctrl #(
      .BOOT_CYCLES  (16'(BOOT_N)),
      .SRST_CYCLES  (16'(SRST_N)),
      .FRAME_CYCLES (16'(FRAME_N))
   ) srs_ctrl_inst (
      .clk     (clk),
      .rst_n   (rst_n),
      .standby (standby),
      .req     (req),
      .rdata   (rdata),
      .ctl     (ctl)
   );

   srs_host_model srs_host_model_inst (
      .clk     (clk),
      .rst_n   (rst_n),
      .standby (standby),
      .req     (req),
      .rdata   (rdata)
   );

   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse counters, since one-cycle pulses are easy to miss by polling
   always @(posedge clk) begin
      if (ctl.mcu_irq === 1'b1) irq_n++;
      if (ctl.wipe === 1'b1) wipe_n++;
   end

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic check_ctl(input string nm, input logic [9:0] m, input logic [9:0] exp);
      check(nm, {6'h00, ctl & m}, {6'h00, exp});
   endtask : check_ctl

   // poll the done bit under a bound, then leave the last read in d
   task automatic poll(input logic want);
      for (int i = 0; i < 40; i++) begin
         srs_host_model_inst.rd(`SRS_OFS_STBY, d);
         if (d[14] === want) break;
      end
   endtask : poll

   task automatic end_of_test();
      if (err_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // watchdog, far beyond the thousand or so cycles the sequence needs
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end

   // main sequence
   initial begin
      err_count  = 0;
      num_checks = 0;
      irq_n      = 0;
      wipe_n     = 0;
      repeat (3) @(negedge clk);
      check_ctl("reset ctl", M_ALL, 10'h0fa);
      srs_host_model_inst.hard_reset();
      srs_host_model_inst.idle(BOOT_N - 4);
      check_ctl("boot core", 10'h200, 10'h000);
      srs_host_model_inst.idle(8);
      check_ctl("boot done", M_ALL, 10'h3e0);
      // register map: read-only done bit, write masks and an unmapped place
      srs_host_model_inst.wr(16'h0020, 16'hffff);
      srs_host_model_inst.rd(16'h0020, d);
      check("unmapped", d, 16'h0000);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'hffd2);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("stby mask", d, 16'h0000);
      srs_host_model_inst.wr(`SRS_OFS_RST, 16'hfffc);
      srs_host_model_inst.rd(`SRS_OFS_RST, d);
      check("rstc mask", d, 16'h0000);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h4024);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("stby rw", d, 16'h0024);
      // soft reset sequence
      srs_host_model_inst.wr(`SRS_OFS_RST, 16'h0003);
      srs_host_model_inst.idle(2);
      check_ctl("srst ctl", 10'h202, 10'h002);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("srst clears", d, 16'h0000);
      srs_host_model_inst.rd(`SRS_OFS_RST, d);
      check("rstc", d, 16'h0003);
      srs_host_model_inst.idle(SRST_N);
      srs_host_model_inst.wr(`SRS_OFS_RST, 16'h0000);
      srs_host_model_inst.idle(2);
      check_ctl("srst exit", M_ALL, 10'h3e0);
      // soft standby entry, stay and exit
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0009);
      srs_host_model_inst.idle(FRAME_N + 28);
      check("irq pulses", 16'(irq_n), 16'h0001);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("entry early", d, 16'h0009);
      poll(1'b1);
      check("soft stby", d, 16'h4009);
      check_ctl("soft ctl", 10'h2a0, 10'h0a0);
      srs_host_model_inst.wr(`SRS_OFS_RST, 16'h0002);
      srs_host_model_inst.rd(`SRS_OFS_RST, d);
      check("sif alive", d, 16'h0002);
      check_ctl("mcu rst", 10'h002, 10'h002);
      srs_host_model_inst.wr(`SRS_OFS_RST, 16'h0000);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0008);
      poll(1'b0);
      check("soft exit", d, 16'h0008);
      check_ctl("soft exit ctl", M_ALL, 10'h3e0);
      // low leakage hard standby, write refused, wiped on release
      srs_host_model_inst.pin(1'b1);
      srs_host_model_inst.idle(FRAME_N + 46);
      check_ctl("ll ctl", M_HS, 10'h018);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0004);
      srs_host_model_inst.idle(FRAME_N + 80);
      k = wipe_n;
      srs_host_model_inst.pin(1'b0);
      srs_host_model_inst.idle(4);
      check("wipe", 16'(wipe_n - k), 16'h0001);
      check_ctl("ll restart", 10'h200, 10'h000);
      // read before the reset so the wipe, not the reset, is what shows
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("ll lost", d, 16'h0000);
      srs_host_model_inst.hard_reset();
      srs_host_model_inst.idle(BOOT_N + 4);
      // high leakage hard standby resumes; a write while gated must not land
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0004);
      srs_host_model_inst.pin(1'b1);
      srs_host_model_inst.idle(FRAME_N + 46);
      check_ctl("hl ctl", M_HS, 10'h038);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0000);
      srs_host_model_inst.idle(FRAME_N + 80);
      srs_host_model_inst.pin(1'b0);
      srs_host_model_inst.idle(3);
      check_ctl("hl resume", M_ALL, 10'h3e0);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("hl kept", d, 16'h0004);
      // high leakage hard standby taken from soft standby returns there
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h000d);
      poll(1'b1);
      check("soft again", d, 16'h400d);
      check("irq again", 16'(irq_n), 16'h0002);
      srs_host_model_inst.pin(1'b1);
      srs_host_model_inst.idle(FRAME_N + 46);
      check_ctl("hl from soft", M_HS, 10'h038);
      srs_host_model_inst.idle(FRAME_N + 80);
      srs_host_model_inst.pin(1'b0);
      srs_host_model_inst.idle(3);
      check_ctl("soft resume", 10'h2a0, 10'h0a0);
      srs_host_model_inst.rd(`SRS_OFS_STBY, d);
      check("soft kept", d, 16'h400d);
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0004);
      poll(1'b0);
      check("soft left", d, 16'h0004);
      // override blocks the standby pin, held for the full standby time
      srs_host_model_inst.wr(`SRS_OFS_STBY, 16'h0020);
      srs_host_model_inst.pin(1'b1);
      srs_host_model_inst.idle(FRAME_N + 124);
      check_ctl("override", M_ALL, 10'h3e0);
      srs_host_model_inst.pin(1'b0);
      srs_host_model_inst.idle(4);
      end_of_test();
   end
endmodule : test_sensor_reset_standby_control
`default_nettype wire
